/* File: pkg/sfthc_pkg.sv */
package sfthc_pkg;

    // =========================================================
    // Sizes
    // =========================================================
    localparam int unsigned RX_DEPTH = 512;
    localparam int unsigned TX_DEPTH = 256;
    localparam int unsigned PTR_W = 12;
    localparam int unsigned OCC_W = 13;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned GR_W = 3;
    localparam int unsigned TX_GR_SHIFT = 2;

    // =========================================================
    // Register indices, byte address is four times the index
    // =========================================================
    localparam logic [15:0] IDX_RX_FLAGS = 16'h2064;
    localparam logic [15:0] IDX_RX_CONTROL = 16'h2068;
    localparam logic [15:0] IDX_RX_THRESHOLD = 16'h206e;
    localparam logic [15:0] IDX_RX_RPTR = 16'h2072;
    localparam logic [15:0] IDX_RX_WPTR = 16'h2076;
    localparam logic [15:0] IDX_RX_LAST_READ = 16'h207a;
    localparam logic [15:0] IDX_RX_LAST_WRITE = 16'h207c;
    localparam logic [15:0] IDX_TX_FLAGS = 16'h2084;
    localparam logic [15:0] IDX_TX_CONTROL = 16'h2088;
    localparam logic [15:0] IDX_TX_THRESHOLD = 16'h208e;
    localparam logic [15:0] IDX_TX_RPTR = 16'h2092;
    localparam logic [15:0] IDX_TX_WPTR = 16'h2096;
    localparam logic [15:0] IDX_SERVICE_ROUTE = 16'h20a0;

    // =========================================================
    // Field positions, counted from the least significant bit
    // =========================================================
    localparam int unsigned ST_ERROR = 6;
    localparam int unsigned ST_UNDERRUN = 5;
    localparam int unsigned ST_OVERRUN = 4;
    localparam int unsigned ST_FULL = 2;
    localparam int unsigned ST_ALARM = 1;
    localparam int unsigned ST_EMPTY = 0;
    localparam int unsigned CT_FRAME = 3;
    localparam int unsigned RT_CPU = 0;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [7:0] CONTROL_RESET = 8'h09;
    localparam logic [11:0] THRESHOLD_RESET = 12'h000;
    localparam logic [11:0] PTR_RESET = 12'h000;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx[ADDR_W-3:0], 2'b00};
    endfunction

endpackage

/* File: src/sfthc_fifo.sv */
// Local design decision: register access over APB.
module sfthc_fifo #(
    parameter int unsigned RX_DEPTH = sfthc_pkg::RX_DEPTH,
    parameter int unsigned TX_DEPTH = sfthc_pkg::TX_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sfthc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_select,
    input wire logic push_strobe,
    input wire logic [sfthc_pkg::DATA_W-1:0] push_data,
    input wire logic pop_strobe,
    output logic [sfthc_pkg::DATA_W-1:0] pop_data,
    output logic fifo_full,
    output logic fifo_empty,
    output logic dma_req,
    output logic cpu_irq
);

    localparam int unsigned MEM_DEPTH = (RX_DEPTH > TX_DEPTH) ? RX_DEPTH : TX_DEPTH;
    localparam int unsigned MEM_AW = $clog2(MEM_DEPTH);
    localparam int unsigned PW = sfthc_pkg::PTR_W;
    localparam int unsigned OW = sfthc_pkg::OCC_W;

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic hit(input logic [sfthc_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
        hit = (a == sfthc_pkg::byte_addr(idx));
    endfunction

    function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p, input logic [OW-1:0] d);
        if ({1'b0, p} == d - 13'h0001) begin
            ptr_step = 12'h000;
        end else begin
            ptr_step = p + 12'h001;
        end
    endfunction

    function automatic logic [31:0] wide16(input logic [15:0] v);
        wide16 = {16'h0000, v};
    endfunction

    // =========================================================
    // Mode and depth
    // =========================================================
    logic tx_mode_q;
    logic [OW-1:0] depth;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_mode_q <= 1'b0;
        end else begin
            tx_mode_q <= tx_select;
        end
    end

    assign depth = tx_mode_q ? OW'(TX_DEPTH) : OW'(RX_DEPTH);

    // =========================================================
    // Register bus decode
    // =========================================================
    logic setup_ph;
    logic wr_acc;
    logic a_flags, a_ctrl, a_thr, a_rptr, a_wptr, a_lrd, a_lwr, a_route;
    logic mapped;

    assign setup_ph = psel && !penable;
    assign a_flags = tx_mode_q ? hit(paddr, sfthc_pkg::IDX_TX_FLAGS)
                               : hit(paddr, sfthc_pkg::IDX_RX_FLAGS);
    assign a_ctrl = tx_mode_q ? hit(paddr, sfthc_pkg::IDX_TX_CONTROL)
                              : hit(paddr, sfthc_pkg::IDX_RX_CONTROL);
    assign a_thr = tx_mode_q ? hit(paddr, sfthc_pkg::IDX_TX_THRESHOLD)
                             : hit(paddr, sfthc_pkg::IDX_RX_THRESHOLD);
    assign a_rptr = tx_mode_q ? hit(paddr, sfthc_pkg::IDX_TX_RPTR)
                              : hit(paddr, sfthc_pkg::IDX_RX_RPTR);
    assign a_wptr = tx_mode_q ? hit(paddr, sfthc_pkg::IDX_TX_WPTR)
                              : hit(paddr, sfthc_pkg::IDX_RX_WPTR);
    assign a_lrd = !tx_mode_q && hit(paddr, sfthc_pkg::IDX_RX_LAST_READ);
    assign a_lwr = !tx_mode_q && hit(paddr, sfthc_pkg::IDX_RX_LAST_WRITE);
    assign a_route = hit(paddr, sfthc_pkg::IDX_SERVICE_ROUTE);
    assign mapped = a_flags || a_ctrl || a_thr || a_rptr || a_wptr || a_lrd || a_lwr
                    || a_route;

    assign wr_acc = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // =========================================================
    // Storage and pointers
    // =========================================================
    logic [sfthc_pkg::DATA_W-1:0] mem [0:MEM_DEPTH-1];
    logic [PW-1:0] rptr_q;
    logic [PW-1:0] wptr_q;
    logic rwrap_q;
    logic wwrap_q;
    logic [OW-1:0] occ;
    logic [OW-1:0] free;
    logic do_push, do_pop;
    logic ev_over, ev_under, ev_bounds;
    logic sw_rptr, sw_wptr;

    assign occ = (rwrap_q == wwrap_q) ? (OW'(wptr_q) - OW'(rptr_q))
                                      : (depth - OW'(rptr_q) + OW'(wptr_q));
    assign free = depth - occ;
    assign fifo_full = (occ == depth);
    assign fifo_empty = (occ == '0);

    assign do_push = push_strobe && !fifo_full;
    assign do_pop = pop_strobe && !fifo_empty;
    assign ev_over = push_strobe && fifo_full;
    assign ev_under = pop_strobe && fifo_empty;
    assign sw_rptr = wr_acc && a_rptr;
    assign sw_wptr = wr_acc && a_wptr;
    assign ev_bounds = (sw_rptr || sw_wptr) && ({1'b0, pwdata[PW-1:0]} >= depth);

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wptr_q[MEM_AW-1:0]] <= push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_data <= '0;
        end else if (do_pop) begin
            pop_data <= mem[rptr_q[MEM_AW-1:0]];
        end
    end

    // Software pointer writes take precedence over hardware advance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_q <= sfthc_pkg::PTR_RESET;
            rwrap_q <= 1'b0;
        end else if (sw_rptr) begin
            if (!ev_bounds) begin
                rptr_q <= pwdata[PW-1:0];
            end
        end else if (do_pop) begin
            rptr_q <= ptr_step(rptr_q, depth);
            if (ptr_step(rptr_q, depth) == '0) begin
                rwrap_q <= !rwrap_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= sfthc_pkg::PTR_RESET;
            wwrap_q <= 1'b0;
        end else if (sw_wptr) begin
            if (!ev_bounds) begin
                wptr_q <= pwdata[PW-1:0];
            end
        end else if (do_push) begin
            wptr_q <= ptr_step(wptr_q, depth);
            if (ptr_step(wptr_q, depth) == '0) begin
                wwrap_q <= !wwrap_q;
            end
        end
    end

    // =========================================================
    // Control, threshold, route and boundary registers
    // =========================================================
    logic [7:0] ctrl_q;
    logic [PW-1:0] thr_q;
    logic route_cpu_q;
    logic [PW-1:0] last_rd_q;
    logic [PW-1:0] last_wr_q;
    logic [sfthc_pkg::GR_W-1:0] release_level_field;

    assign release_level_field = ctrl_q[sfthc_pkg::GR_W-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= sfthc_pkg::CONTROL_RESET;
        end else if (wr_acc && a_ctrl) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q <= sfthc_pkg::THRESHOLD_RESET;
        end else if (wr_acc && a_thr) begin
            thr_q <= pwdata[PW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_cpu_q <= 1'b0;
        end else if (wr_acc && a_route) begin
            route_cpu_q <= pwdata[sfthc_pkg::RT_CPU];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_rd_q <= sfthc_pkg::PTR_RESET;
            last_wr_q <= sfthc_pkg::PTR_RESET;
        end else begin
            if (wr_acc && a_lrd) begin
                last_rd_q <= pwdata[PW-1:0];
            end
            if (wr_acc && a_lwr) begin
                last_wr_q <= pwdata[PW-1:0];
            end
        end
    end

    // =========================================================
    // Service request
    // =========================================================
    logic raise;
    logic drop;
    logic alarm_q;
    logic [OW-1:0] tx_release;

    assign tx_release = OW'(release_level_field) << sfthc_pkg::TX_GR_SHIFT;
    assign raise = tx_mode_q ? (occ < OW'(thr_q))
                             : (free < OW'(thr_q));
    assign drop = tx_mode_q ? (free <= tx_release)
                            : (occ < OW'(release_level_field));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_q <= 1'b0;
        end else if (route_cpu_q) begin
            alarm_q <= raise;
        end else if (raise) begin
            alarm_q <= 1'b1;
        end else if (drop) begin
            alarm_q <= 1'b0;
        end
    end

    assign dma_req = alarm_q && !route_cpu_q;
    assign cpu_irq = alarm_q && route_cpu_q;

    // =========================================================
    // Sticky flags, write one to clear, set wins
    // =========================================================
    logic err_q, under_q, over_q;
    logic clr_flags;

    assign clr_flags = wr_acc && a_flags;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
            under_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            err_q <= (ev_over || ev_under || ev_bounds)
                     || (err_q && !(clr_flags && pwdata[sfthc_pkg::ST_ERROR]));
            under_q <= ev_under
                       || (under_q && !(clr_flags && pwdata[sfthc_pkg::ST_UNDERRUN]));
            over_q <= ev_over
                      || (over_q && !(clr_flags && pwdata[sfthc_pkg::ST_OVERRUN]));
        end
    end

    // =========================================================
    // Read data, captured in the setup phase
    // =========================================================
    logic [15:0] status;
    logic [31:0] rd_mux;

    always_comb begin
        status = '0;
        status[sfthc_pkg::ST_ERROR] = err_q;
        status[sfthc_pkg::ST_UNDERRUN] = under_q;
        status[sfthc_pkg::ST_OVERRUN] = over_q;
        status[sfthc_pkg::ST_FULL] = fifo_full;
        status[sfthc_pkg::ST_ALARM] = alarm_q;
        status[sfthc_pkg::ST_EMPTY] = fifo_empty;
    end

    always_comb begin
        rd_mux = '0;
        if (a_flags) begin
            rd_mux = wide16(status);
        end else if (a_ctrl) begin
            rd_mux = {24'h000000, ctrl_q};
        end else if (a_thr) begin
            rd_mux = {20'h00000, thr_q};
        end else if (a_rptr) begin
            rd_mux = {20'h00000, rptr_q};
        end else if (a_wptr) begin
            rd_mux = {20'h00000, wptr_q};
        end else if (a_lrd) begin
            rd_mux = {20'h00000, last_rd_q};
        end else if (a_lwr) begin
            rd_mux = {20'h00000, last_wr_q};
        end else if (a_route) begin
            rd_mux = {31'h00000000, route_cpu_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_mux;
        end
    end

endmodule

/* File: test/sfthc_fifo_monitor.sv */
module sfthc_fifo_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic push_strobe,
    input wire logic pop_strobe,
    input wire logic [sfthc_pkg::DATA_W-1:0] pop_data,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic dma_req,
    input wire logic cpu_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Port relations
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_full_empty; !(fifo_full && fifo_empty); endproperty
    a_full_empty: assert property (p_full_empty) else $error("full with empty");
    property p_overrun; fifo_full && push_strobe && !pop_strobe |=> fifo_full; endproperty
    a_overrun: assert property (p_overrun) else $error("push when full lost");
    property p_underrun; fifo_empty && pop_strobe && !push_strobe |=> fifo_empty; endproperty
    a_underrun: assert property (p_underrun) else $error("pop when empty");
    property p_hold; !pop_strobe || fifo_empty |=> $stable(pop_data); endproperty
    a_hold: assert property (p_hold) else $error("pop data moved");
    property p_fill; fifo_empty && push_strobe && !pop_strobe |=> !fifo_empty; endproperty
    a_fill: assert property (p_fill) else $error("push not stored");
    property p_drain; fifo_full && pop_strobe && !push_strobe |=> !fifo_full; endproperty
    a_drain: assert property (p_drain) else $error("pop not taken");
    property p_route; !(dma_req && cpu_irq); endproperty
    a_route: assert property (p_route) else $error("both targets requested");
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_setup; psel && !penable |-> !pslverr; endproperty
    a_setup: assert property (p_setup) else $error("error in setup");
endmodule

/* File: test/sfthc_servicer.sv */
module sfthc_servicer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic tx_mode,
    input wire logic dma_req,
    input wire logic [7:0] pop_data,
    output logic push_strobe,
    output logic [7:0] push_data,
    output logic pop_strobe,
    output int bad_count
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // One byte every third cycle while requested
    logic [1:0] gap_q;
    logic [7:0] idx_q;
    logic chk_q;
    logic go;
    assign go = en && dma_req && gap_q == 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 2'h0;
            idx_q <= 8'h00;
            chk_q <= 1'b0;
            push_strobe <= 1'b0;
            pop_strobe <= 1'b0;
            push_data <= 8'h00;
            bad_count <= 0;
        end else begin
            gap_q <= go ? 2'h2 : (gap_q == 2'h0 ? 2'h0 : gap_q - 2'h1);
            push_strobe <= go && tx_mode;
            pop_strobe <= go && !tx_mode;
            push_data <= idx_q;
            if (go) idx_q <= idx_q + 8'h01;
            chk_q <= pop_strobe;
            // Popped bytes must come back in push order
            if (chk_q && pop_data !== idx_q - 8'h01) bad_count <= bad_count + 1;
        end
    end
endmodule

/* File: test/serial_fifo_threshold_ctrl_tb.sv */
module serial_fifo_threshold_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, tx_select;
    logic tb_push, tb_pop, sv_en, sv_push, sv_pop, push_strobe, pop_strobe;
    logic fifo_full, fifo_empty, dma_req, cpu_irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] tb_data, sv_data, push_data, pop_data;
    int sv_bad;
    int pcount = 0;
    int miscompares = 0;
    int num_checks = 0;
    assign push_strobe = tb_push | sv_push;
    assign push_data = sv_push ? sv_data : tb_data;
    assign pop_strobe = tb_pop | sv_pop;
    sfthc_fifo sfthc_fifo_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_select(tx_select), .push_strobe(push_strobe),
        .push_data(push_data), .pop_strobe(pop_strobe), .pop_data(pop_data),
        .fifo_full(fifo_full), .fifo_empty(fifo_empty), .dma_req(dma_req), .cpu_irq(cpu_irq));
    sfthc_servicer sfthc_servicer_inst (.pclk(pclk), .presetn(presetn), .en(sv_en),
        .tx_mode(tx_select), .dma_req(dma_req), .pop_data(pop_data), .push_strobe(sv_push),
        .push_data(sv_data), .pop_strobe(sv_pop), .bad_count(sv_bad));
    // ==========================================
    // Bus and stream tasks
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle so a following call never reassigns psel in this step
        @(posedge pclk);
        if (n >= 16) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic push_n(input int n);
        for (int i = 0; i < n; i++) begin
            tb_push <= 1'b1;
            tb_data <= pcount[7:0];
            pcount++;
            @(posedge pclk);
        end
        tb_push <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic pop1();
        tb_pop <= 1'b1;
        @(posedge pclk);
        tb_pop <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic drain();
        int n;
        n = 0;
        sv_en <= 1'b1;
        do begin
            @(negedge pclk);
            n++;
        end while (dma_req !== 1'b0 && n < 4000);
        @(posedge pclk);
        sv_en <= 1'b0;
        repeat (4) @(posedge pclk);
        if (n >= 4000) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_rx_basic();
        chk("empty pin", fifo_empty, 1'b1);
        rdchk(sfthc_pkg::IDX_RX_CONTROL, 32'h09, "rx control");
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h01, "rx flags");
        rdchk(sfthc_pkg::IDX_TX_CONTROL, 32'h0, "tx map data");
        chk("tx map err", er, 1'b1);
        apb(1'b1, sfthc_pkg::IDX_RX_THRESHOLD, 32'hffff_ffff);
        rdchk(sfthc_pkg::IDX_RX_THRESHOLD, 32'h0fff, "threshold width");
        pop1();
        // Free space 512 is below threshold 0xfff, so the alarm bit stands too
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h63, "underrun");
        apb(1'b1, sfthc_pkg::IDX_RX_FLAGS, 32'h60);
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h03, "underrun clear");
        $display("Test rx basic done");
    endtask
    task automatic t_rx_hyst();
        apb(1'b1, sfthc_pkg::IDX_RX_THRESHOLD, 32'h8);
        apb(1'b1, sfthc_pkg::IDX_RX_CONTROL, 32'h03);
        push_n(504);
        chk("free 8 quiet", dma_req, 1'b0);
        push_n(1);
        chk("free 7 request", dma_req, 1'b1);
        push_n(7);
        chk("full at 512", fifo_full, 1'b1);
        push_n(1);
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h56, "overrun");
        apb(1'b1, sfthc_pkg::IDX_RX_FLAGS, 32'h70);
        drain();
        chk("rx order", sv_bad, 0);
        rdchk(sfthc_pkg::IDX_RX_RPTR, 32'h1fe, "release at 2");
        rdchk(sfthc_pkg::IDX_RX_WPTR, 32'h0, "write wrap");
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h0, "flags clear");
        $display("Test rx hysteresis done");
    endtask
    task automatic t_rx_cpu();
        apb(1'b1, sfthc_pkg::IDX_SERVICE_ROUTE, 32'h1);
        apb(1'b1, sfthc_pkg::IDX_RX_THRESHOLD, 32'h1ff);
        repeat (2) @(posedge pclk);
        chk("cpu raise", cpu_irq, 1'b1);
        chk("dma quiet", dma_req, 1'b0);
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h02, "alarm flag");
        apb(1'b1, sfthc_pkg::IDX_RX_THRESHOLD, 32'h1fe);
        repeat (2) @(posedge pclk);
        chk("cpu drop", cpu_irq, 1'b0);
        apb(1'b1, sfthc_pkg::IDX_RX_RPTR, 32'h200);
        rdchk(sfthc_pkg::IDX_RX_RPTR, 32'h1fe, "pointer kept");
        rdchk(sfthc_pkg::IDX_RX_FLAGS, 32'h40, "pointer error");
        $display("Test rx cpu done");
    endtask
    task automatic t_tx();
        tx_select <= 1'b1;
        do_reset();
        rdchk(sfthc_pkg::IDX_TX_CONTROL, 32'h09, "tx control");
        rdchk(sfthc_pkg::IDX_RX_THRESHOLD, 32'h0, "rx map data");
        chk("rx map err", er, 1'b1);
        apb(1'b1, sfthc_pkg::IDX_TX_THRESHOLD, 32'h10);
        apb(1'b1, sfthc_pkg::IDX_TX_CONTROL, 32'h02);
        repeat (2) @(posedge pclk);
        chk("tx request", dma_req, 1'b1);
        drain();
        rdchk(sfthc_pkg::IDX_TX_WPTR, 32'h0f8, "release at free 8");
        pop1();
        chk("tx order", pop_data, 8'h00);
        chk("no raise at 247", dma_req, 1'b0);
        $display("Test tx done");
    endtask
    initial begin
        {psel, penable, pwrite, tx_select, tb_push, tb_pop, sv_en} <= 7'h00;
        paddr <= 16'h0000;
        pwdata <= 32'h0;
        tb_data <= 8'h00;
        do_reset();
        t_rx_basic();
        t_rx_hyst();
        t_rx_cpu();
        t_tx();
        stop_test();
    end
endmodule
bind sfthc_fifo sfthc_fifo_monitor sfthc_fifo_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .push_strobe(push_strobe), .pop_strobe(pop_strobe), .pop_data(pop_data),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty), .dma_req(dma_req), .cpu_irq(cpu_irq));
